/* File: hw/bps_cfg.svh */
`ifndef BPS_CFG_SVH
`define BPS_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BPS_CLK_MHZ      100
`define BPS_FMIN_KHZ     200
`define BPS_FMAX_KHZ     2300
`define BPS_FALLBACK_KHZ 100
`define BPS_PER_MAX      ((`BPS_CLK_MHZ * 1000) / `BPS_FMIN_KHZ)
`define BPS_PER_MIN      ((`BPS_CLK_MHZ * 1000) / `BPS_FMAX_KHZ)
`define BPS_PER_FB       ((`BPS_CLK_MHZ * 1000) / `BPS_FALLBACK_KHZ)
`define BPS_LOSS_CYC     (2 * `BPS_PER_MAX)
`define BPS_OVL_LIMIT    256
`define BPS_HICCUP_CYC   8192
`define BPS_FB_CYC       16

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define BPS_ADDR_CTRL    12'h000
`define BPS_ADDR_RDIV    12'h004
`define BPS_ADDR_STATUS  12'h008
`define BPS_CTRL_EN_BIT  0
`define BPS_CTRL_RST     1'h1
`define BPS_RDIV_RST     16'h00C8

`endif

/* File: hw/bps_pkg.sv */
package bps_pkg;

  typedef enum logic [3:0] {
    BPS_OFF  = 4'h1,
    BPS_SOFT = 4'h2,
    BPS_RUN  = 4'h4,
    BPS_HIC  = 4'h8
  } bps_ch_st_t;

  typedef enum logic [2:0] {
    BPS_RES  = 3'h1,
    BPS_SYNC = 3'h2,
    BPS_FALL = 3'h4
  } bps_clk_st_t;

endpackage : bps_pkg

/* File: hw/bps_top.sv */
// What this block does
// - Peak current hit ends high-side on-time
// - Source overlimit at cycle end holds low-side
// - High-side resumes only when source current ok
// - Sink overlimit turns both off until next cycle
// - Overload over 256 cycles enters hiccup
// - Hiccup waits 8192 cycles then restarts
// - Power good released inside 95/105 window
// - Power good pulled outside 92.5/107.5 limits
// - Power good low on lockout, heat, disable, softstart
// - Sync mode starts cycle on falling edge
// - Lock only to 200 to 2300 kHz clock
// - Resistor mode until external clock appears
// - First rising edge enters sync, pin released
// - Clock loss falls back to 100 kHz first
// - Over-temperature stops switching on all channels
// - Temperature clear restarts power-up sequence
// - Enabled channel runs forced continuous, fixed frequency
// - Enable low puts channel into standby
// - First channel runs 180 degrees from others
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "bps_cfg.svh"
`default_nettype none

module bps_top
  import bps_pkg::*;
#(
  parameter int HICCUP_CYCLES = `BPS_HICCUP_CYC,
  parameter int OVL_LIMIT     = `BPS_OVL_LIMIT,
  parameter int FB_CYCLES     = `BPS_FB_CYC
) (
  input  wire  logic        sys_clk_in,          // 100 MHz
  input  wire  logic        reset_in,            // Async, high
  input  wire  logic        psel_in,             // APB select
  input  wire  logic        penable_in,          // APB enable
  input  wire  logic        pwrite_in,           // APB write
  input  wire  logic [11:0] paddr_in,            // APB address
  input  wire  logic [31:0] pwdata_in,           // APB write data
  output logic       [31:0] prdata_out,          // APB read data
  output logic              pready_out,          // APB ready
  output logic              pslverr_out,         // APB error
  input  wire  logic        supply_lockout_in,   // Input lockout
  input  wire  logic        over_temp_in,        // 160C trip, 140C clear
  input  wire  logic [2:0]  channel_enable_pin_in, // Enable above thr
  input  wire  logic [2:0]  ramp_cap_done_in,    // Soft-start complete
  input  wire  logic [2:0]  fb_in_window_in,     // Inside 95/105
  input  wire  logic [2:0]  fb_fault_in,         // Out of 92.5/107.5
  input  wire  logic [2:0]  peak_hit_in,         // Peak current reached
  input  wire  logic [2:0]  ls_src_over_in,      // LS source overlimit
  input  wire  logic [2:0]  ls_sink_over_in,     // LS sink overlimit
  input  wire  logic [2:0]  eamp_overload_in,    // Error amp overload
  input  wire  logic        freq_set_pin_in,     // Pin above 2 V
  output logic              freq_set_pin_out,    // Pin drive level
  output logic              freq_set_pin_oe_out, // Pin driven
  output logic       [2:0]  hs_on_out,           // High-side gate
  output logic       [2:0]  ls_on_out,           // Low-side gate
  output logic       [2:0]  ramp_cap_dis_out,    // Soft-start discharge
  output logic              output_ok_flag_out,  // Open-drain level
  output logic              output_ok_flag_oe_out // Pulldown active
);

  localparam int HW = $clog2(HICCUP_CYCLES);
  localparam int OW = $clog2(OVL_LIMIT) + 1;
  localparam int FW = $clog2(FB_CYCLES) + 1;

  function automatic logic bps_hit(input logic [11:0] a,
                                   input logic [11:0] o);
    return a[11:2] == o[11:2];
  endfunction : bps_hit

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 27;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  wire  [SW-1:0] raw = {supply_lockout_in, over_temp_in,
                        channel_enable_pin_in, ramp_cap_done_in,
                        fb_in_window_in, fb_fault_in, peak_hit_in,
                        ls_src_over_in, ls_sink_over_in,
                        eamp_overload_in, freq_set_pin_in};

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  wire       lock_s = s2_q[26];
  wire       temp_s = s2_q[25];
  wire [2:0] en_s   = s2_q[24:22];
  wire [2:0] ss_s   = s2_q[21:19];
  wire [2:0] win_s  = s2_q[18:16];
  wire [2:0] flt_s  = s2_q[15:13];
  wire [2:0] pk_s   = s2_q[12:10];
  wire [2:0] src_s  = s2_q[9:7];
  wire [2:0] snk_s  = s2_q[6:4];
  wire [2:0] ovl_s  = s2_q[3:1];
  wire       fset_s = s2_q[0];

  // ----------------------------------------------------------------
  // Switching clock
  // ----------------------------------------------------------------
  bps_clk_st_t clk_st_q;
  bps_clk_st_t clk_d;
  logic        fset_d_q;
  logic [15:0] per_cnt_q;
  logic [15:0] last_per_q;
  logic [15:0] rdiv_q;
  logic [FW-1:0] fb_cnt_q;
  logic        conv_en_q;

  wire in_sync = clk_st_q == BPS_SYNC;
  wire fall_e  = fset_d_q & ~fset_s;
  wire rise_e  = ~fset_d_q & fset_s;
  wire [15:0] per_nx  = per_cnt_q + 16'h0001;
  wire [15:0] res_per = (clk_st_q == BPS_FALL) ? 16'(`BPS_PER_FB)
                                               : rdiv_q;
  wire in_rng = per_nx >= 16'(`BPS_PER_MIN) &&
                per_nx <= 16'(`BPS_PER_MAX);
  wire start_b = in_sync ? (fall_e && in_rng)
                         : (per_nx >= res_per);
  wire [15:0] cur_per = in_sync ? last_per_q : res_per;
  wire start_h = per_nx == {1'b0, cur_per[15:1]};
  wire loss    = in_sync && per_cnt_q >= 16'(`BPS_LOSS_CYC);
  wire fb_done = start_b && fb_cnt_q == FW'(FB_CYCLES - 1);

  always_comb begin
    case (clk_st_q)
      BPS_RES:  clk_d = rise_e ? BPS_SYNC : BPS_RES;
      BPS_SYNC: clk_d = loss ? BPS_FALL : BPS_SYNC;
      BPS_FALL: clk_d = fb_done ? BPS_RES : BPS_FALL;
      default:  clk_d = BPS_RES;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      clk_st_q   <= BPS_RES;
      fset_d_q   <= 1'b0;
      per_cnt_q  <= '0;
      last_per_q <= 16'(`BPS_PER_MAX);
      fb_cnt_q   <= '0;
      freq_set_pin_oe_out <= 1'b1;
    end else begin
      clk_st_q <= clk_d;
      fset_d_q <= fset_s;
      freq_set_pin_oe_out <= clk_d != BPS_SYNC;
      if (start_b || (in_sync && fall_e) || clk_d != clk_st_q)
        per_cnt_q <= '0;
      else if (per_cnt_q != 16'hFFFF)
        per_cnt_q <= per_nx;
      if (start_b)
        last_per_q <= per_nx;
      if (clk_st_q != BPS_FALL)
        fb_cnt_q <= '0;
      else if (start_b)
        fb_cnt_q <= fb_cnt_q + FW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  logic [2:0] pg_ch_q;
  logic [2:0] run_v;
  logic [2:0] hic_v;

  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  for (genvar i = 0; i < 3; i++) begin : g_ch
    bps_ch_st_t st_q;
    bps_ch_st_t st_d;
    logic [OW-1:0] ovl_q;
    logic [HW-1:0] hic_q;
    logic          blk_q;
    wire start  = (i == 0) ? start_h : start_b;
    wire en_ok  = conv_en_q & en_s[i] & ~lock_s & ~temp_s;
    wire active = st_q == BPS_SOFT || st_q == BPS_RUN;
    wire ovl_trip = start && ovl_s[i] && ovl_q == OW'(OVL_LIMIT);
    wire hic_end  = start && hic_q == HW'(HICCUP_CYCLES - 1);

    always_comb begin
      case (st_q)
        BPS_OFF:  st_d = en_ok ? BPS_SOFT : BPS_OFF;
        BPS_SOFT: st_d = !en_ok ? BPS_OFF :
                         ss_s[i] ? BPS_RUN : BPS_SOFT;
        BPS_RUN:  st_d = !en_ok ? BPS_OFF :
                         ovl_trip ? BPS_HIC : BPS_RUN;
        BPS_HIC:  st_d = !en_ok ? BPS_OFF :
                         hic_end ? BPS_SOFT : BPS_HIC;
        default:  st_d = BPS_OFF;
      endcase
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
        st_q  <= BPS_OFF;
        ovl_q <= '0;
        hic_q <= '0;
      end else begin
        st_q <= st_d;
        if (st_q != BPS_RUN || (start && !ovl_s[i]))
          ovl_q <= '0;
        else if (start && ovl_q != OW'(OVL_LIMIT))
          ovl_q <= ovl_q + OW'(1);
        if (st_q != BPS_HIC)
          hic_q <= '0;
        else if (start)
          hic_q <= hic_q + HW'(1);
      end
    end

    // From the first cycle start in SOFT/RUN, low side conducts whenever high side is off, except after a sink overlimit until the next cycle: forced CCM
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
        hs_on_out[i] <= 1'b0;
        ls_on_out[i] <= 1'b0;
        blk_q        <= 1'b0;
      end else if (!active || st_d == BPS_OFF) begin
        hs_on_out[i] <= 1'b0;
        ls_on_out[i] <= 1'b0;
        blk_q        <= 1'b0;
      end else if (start) begin
        hs_on_out[i] <= !src_s[i];
        ls_on_out[i] <= src_s[i];
        blk_q        <= 1'b0;
      end else if (hs_on_out[i] && pk_s[i]) begin
        hs_on_out[i] <= 1'b0;
        ls_on_out[i] <= !blk_q;
      end else if (ls_on_out[i] && snk_s[i]) begin
        ls_on_out[i] <= 1'b0;
        blk_q        <= 1'b1;
      end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
        pg_ch_q[i]          <= 1'b0;
        ramp_cap_dis_out[i] <= 1'b1;
      end else begin
        ramp_cap_dis_out[i] <= st_d == BPS_OFF || st_d == BPS_HIC;
        if (st_q != BPS_RUN || flt_s[i])
          pg_ch_q[i] <= 1'b0;
        else if (win_s[i])
          pg_ch_q[i] <= 1'b1;
      end
    end

    assign run_v[i] = st_q == BPS_RUN;
    assign hic_v[i] = st_q == BPS_HIC;

    sequence s_trip;
      temp_s ##1 st_q == BPS_OFF;
    endsequence

    peak_off_a: assert property (
      hs_on_out[i] && pk_s[i] && !start && active && st_d != BPS_OFF
      |=> !hs_on_out[i] && (ls_on_out[i] == !blk_q))
      else $error("high side not ended by peak current");
    src_hold_a: assert property (
      start && active && st_d != BPS_OFF && src_s[i]
      |=> !hs_on_out[i] && ls_on_out[i])
      else $error("source overlimit did not hold low side");
    hs_resume_a: assert property (
      start && active && st_d != BPS_OFF && !src_s[i]
      |=> hs_on_out[i] && !ls_on_out[i])
      else $error("high side not resumed at cycle start");
    sink_off_a: assert property (
      ls_on_out[i] && snk_s[i] && !start && !hs_on_out[i]
      |=> !ls_on_out[i] && !hs_on_out[i])
      else $error("sink overlimit did not turn off");
    hiccup_enter_a: assert property (
      st_q == BPS_RUN && en_ok && ovl_trip |=> st_q == BPS_HIC)
      else $error("overload did not enter hiccup");
    ovl_clear_a: assert property (
      st_q == BPS_RUN && start && !ovl_s[i] |=> ovl_q == '0)
      else $error("overload counter not cleared");
    therm_stop_a: assert property (
      temp_s |-> s_trip ##1 !hs_on_out[i] && !ls_on_out[i])
      else $error("switching not stopped on over-temp");
  end

  // ----------------------------------------------------------------
  // Power good
  // ----------------------------------------------------------------
  // Enable checked directly: a channel leaving RUN clears its bit a cycle late
  wire pg_ok = &pg_ch_q & ~lock_s & ~temp_s & conv_en_q & (&en_s);

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      output_ok_flag_oe_out <= 1'b1;
      output_ok_flag_out    <= 1'b0;
      freq_set_pin_out      <= 1'b0;
    end else begin
      output_ok_flag_oe_out <= !pg_ok;
      output_ok_flag_out    <= 1'b0;
      freq_set_pin_out      <= 1'b0;
    end
  end

  pg_low_a: assert property (
    (lock_s || temp_s || !(&en_s)) |=> output_ok_flag_oe_out)
    else $error("power good not pulled low");
  sync_enter_a: assert property (
    clk_st_q == BPS_RES && rise_e
    |=> clk_st_q == BPS_SYNC && !freq_set_pin_oe_out)
    else $error("sync mode not entered");
  loss_fall_a: assert property (
    loss |=> clk_st_q == BPS_FALL)
    else $error("clock loss did not fall back");

  // ----------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------
  wire hit_ctrl = bps_hit(paddr_in, `BPS_ADDR_CTRL);
  wire hit_rdiv = bps_hit(paddr_in, `BPS_ADDR_RDIV);
  wire hit_stat = bps_hit(paddr_in, `BPS_ADDR_STATUS);
  wire hit_any  = hit_ctrl | hit_rdiv | hit_stat;
  wire acc      = psel_in & penable_in;
  wire wr_done  = acc & pready_out & pwrite_in;
  wire [31:0] status = {16'h0000, 3'h0, clk_st_q, hic_v, run_v,
                        output_ok_flag_oe_out, pg_ch_q};
  wire [31:0] rd_mux = hit_ctrl ? {31'h0, conv_en_q} :
                       hit_rdiv ? {16'h0000, rdiv_q} :
                       hit_stat ? status : 32'h00000000;

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
    end else begin
      pready_out  <= acc & ~pready_out;
      pslverr_out <= acc & ~pready_out & ~hit_any;
      if (acc && !pready_out && !pwrite_in)
        prdata_out <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      conv_en_q <= `BPS_CTRL_RST;
      rdiv_q    <= `BPS_RDIV_RST;
    end else if (wr_done) begin
      if (hit_ctrl)
        conv_en_q <= pwdata_in[`BPS_CTRL_EN_BIT];
      if (hit_rdiv)
        rdiv_q <= pwdata_in[15:0];
    end
  end

endmodule : bps_top

`default_nettype wire

/* File: tb/bps_stage_model.sv */
`timescale 1ns/1ns
`default_nettype none
module bps_stage_model (
  input  wire logic       clk_in,   // System clock
  input  wire logic [2:0] hs_in,    // High-side gates
  input  wire logic [2:0] dis_in,   // Ramp discharge
  input  wire logic [7:0] dly_in,   // On-time to peak trip
  input  wire logic       ext_in,   // External clock on
  input  wire logic [9:0] half_in,  // Half period, sys cycles
  output logic      [2:0] peak_out, // Peak comparators
  output logic      [2:0] done_out, // Ramp complete
  output logic            pin_out   // Freq-set pin level
);
  logic [7:0] on_q [3];
  logic [7:0] ss_q [3];
  logic [9:0] ph_q = 10'h000;
  logic       ck_q = 1'b0;
  // Pin resistor pulls low once the source stops
  assign pin_out = ext_in & ck_q;
  always @(posedge clk_in) begin
    for (int i = 0; i < 3; i++) begin
      on_q[i] <= hs_in[i] ? on_q[i] + 8'h01 : 8'h00;
      peak_out[i] <= hs_in[i] && on_q[i] >= dly_in;
      ss_q[i] <= dis_in[i] ? 8'h00 : ss_q[i] + {7'h00, !done_out[i]};
      done_out[i] <= !dis_in[i] && ss_q[i] >= 8'h28;
    end
    ph_q <= (ph_q + 10'h001 >= half_in) ? 10'h000 : ph_q + 10'h001;
    if (ph_q + 10'h001 >= half_in)
      ck_q <= ext_in & !ck_q;
  end
endmodule : bps_stage_model
`default_nettype wire

/* File: tb/test_buck_protection_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module test_buck_protection_sequencer;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [2:0]  en = 3'h0;
  logic [2:0]  win = 3'h0;
  logic [2:0]  flt = 3'h0;
  logic [2:0]  src = 3'h0;
  logic [2:0]  snk = 3'h0;
  logic [2:0]  ovl = 3'h0;
  logic        uv = 1'b0;
  logic        ot = 1'b0;
  logic [7:0]  dly = 8'h14;
  logic        ext = 1'b0;
  logic [9:0]  half = 10'h032;
  logic [31:0] prd;
  logic        prdy, perr, pin, fso, fsoe, oko, okoe;
  logic [2:0]  pk, sd, hs, ls, dis;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cyc = 0;

  always #5 clk = ~clk;

  bps_top #(.HICCUP_CYCLES(16), .OVL_LIMIT(4), .FB_CYCLES(4)) u_bps_top (
    .sys_clk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .supply_lockout_in(uv),
    .over_temp_in(ot), .channel_enable_pin_in(en), .ramp_cap_done_in(sd),
    .fb_in_window_in(win), .fb_fault_in(flt), .peak_hit_in(pk),
    .ls_src_over_in(src), .ls_sink_over_in(snk), .eamp_overload_in(ovl),
    .freq_set_pin_in(pin), .freq_set_pin_out(fso),
    .freq_set_pin_oe_out(fsoe), .hs_on_out(hs), .ls_on_out(ls),
    .ramp_cap_dis_out(dis), .output_ok_flag_out(oko),
    .output_ok_flag_oe_out(okoe));

  bps_stage_model u_bps_stage_model (
    .clk_in(clk), .hs_in(hs), .dis_in(dis), .dly_in(dly), .ext_in(ext),
    .half_in(half), .peak_out(pk), .done_out(sd), .pin_out(pin));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  function automatic logic probe(input int s);
    logic [11:0] v;
    v = {pin, fsoe, okoe, dis, ls, hs};
    return v[s];
  endfunction : probe

  // Bounded so a stuck output ends as a mismatch, not a hang
  task automatic wait_on(input int s, input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (probe(s) !== v && n < 5000);
  endtask : wait_on

  task automatic period(input int c, output int p);
    int n;
    wait_on(c, 1'b0, n);
    wait_on(c, 1'b1, n);
    wait_on(c, 1'b0, p);
    wait_on(c, 1'b1, n);
    p = p + n;
  endtask : period

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [32:0] r);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 50);
    r = {perr, prd};
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [32:0] r;
    apb(1'b0, 12'h000, 32'h0, r);
    check(r, 33'h000000001);
    apb(1'b0, 12'h004, 32'h0, r);
    check(r, 33'h0000000C8);
    apb(1'b1, 12'h004, 32'h64, r);
    apb(1'b0, 12'h004, 32'h0, r);
    check(r, 33'h000000064);
    apb(1'b0, 12'h00C, 32'h0, r);
    check(r, 33'h100000000);
    apb(1'b0, 12'h008, 32'h0, r);
    check(r[12:10], 3'h1);
    $display("Test registers done");
  endtask : t_regs

  task automatic t_start;
    int n;
    @(posedge clk);
    en <= 3'h7;
    win <= 3'h5;
    wait_on(7, 1'b0, n);
    check(okoe, 1'b1);
    wait_on(1, 1'b1, n);
    check(n < 200, 1'b1);
    tick(300);
    check(okoe, 1'b1);
    win <= 3'h7;
    wait_on(9, 1'b0, n);
    check(n < 50, 1'b1);
    $display("Test start done");
  endtask : t_start

  task automatic t_switch;
    int n;
    int d;
    for (int i = 0; i < 2; i++) begin
      d = 20 + 40 * i;
      dly <= d[7:0];
      tick(200);
      wait_on(1, 1'b0, n);
      wait_on(1, 1'b1, n);
      wait_on(1, 1'b0, n);
      check(n > d && n < d + 7, 1'b1);
      check(ls[1], 1'b1);
    end
    dly <= 8'h14;
    wait_on(1, 1'b0, n);
    wait_on(1, 1'b1, n);
    wait_on(0, 1'b1, n);
    check(n, 50);
    $display("Test switching done");
  endtask : t_switch

  task automatic t_limits;
    int n;
    logic h = 1'b0;
    logic l = 1'b1;
    wait_on(1, 1'b0, n);
    src <= 3'h2;
    tick(150);
    repeat (200) begin
      @(posedge clk);
      h |= hs[1];
      l &= ls[1];
    end
    check({h, l}, 2'b01);
    src <= 3'h0;
    wait_on(1, 1'b1, n);
    check(n < 105, 1'b1);
    wait_on(1, 1'b0, n);
    tick(5);
    snk <= 3'h2;
    tick(1);
    snk <= 3'h0;
    tick(5);
    check({hs[1], ls[1]}, 2'b00);
    wait_on(1, 1'b1, n);
    check(n < 100, 1'b1);
    $display("Test current limits done");
  endtask : t_limits

  task automatic t_good;
    int n;
    flt <= 3'h4;
    tick(6);
    check(okoe, 1'b1);
    flt <= 3'h0;
    wait_on(9, 1'b0, n);
    check(n < 50, 1'b1);
    en <= 3'h5;
    tick(150);
    check({hs[1], ls[1], okoe}, 3'b001);
    uv <= 1'b1;
    tick(6);
    check({hs, ls, okoe}, 7'h01);
    check({oko, fso}, 2'h0);
    uv <= 1'b0;
    en <= 3'h7;
    wait_on(9, 1'b0, n);
    check(n < 400, 1'b1);
    $display("Test power good done");
  endtask : t_good

  task automatic t_hiccup;
    int n;
    logic s = 1'b0;
    for (int k = 0; k < 2; k++) begin
      ovl <= 3'h2;
      repeat (350) begin
        @(posedge clk);
        s |= dis[1];
      end
      ovl <= 3'h0;
      repeat (150) begin
        @(posedge clk);
        s |= dis[1];
      end
    end
    check(s, 1'b0);
    ovl <= 3'h2;
    wait_on(7, 1'b1, n);
    check(n > 400 && n < 510, 1'b1);
    tick(2);
    check({hs[1], ls[1], okoe}, 3'b001);
    ovl <= 3'h0;
    wait_on(7, 1'b0, n);
    check(n > 1500 && n < 1700, 1'b1);
    check(okoe, 1'b1);
    wait_on(9, 1'b0, n);
    check(n < 300, 1'b1);
    $display("Test hiccup done");
  endtask : t_hiccup

  task automatic t_therm;
    int n;
    ot <= 1'b1;
    tick(300);
    check({hs, ls, okoe}, 7'h01);
    ot <= 1'b0;
    wait_on(7, 1'b0, n);
    check(okoe, 1'b1);
    wait_on(9, 1'b0, n);
    check(n < 400, 1'b1);
    $display("Test thermal done");
  endtask : t_therm

  task automatic t_sync;
    int n;
    logic [32:0] r;
    logic h = 1'b0;
    ext <= 1'b1;
    wait_on(10, 1'b0, n);
    check(n < 300, 1'b1);
    apb(1'b0, 12'h008, 32'h0, r);
    check(r[12:10], 3'h2);
    wait_on(11, 1'b1, n);
    wait_on(11, 1'b0, n);
    wait_on(1, 1'b1, n);
    check(n < 7, 1'b1);
    period(1, n);
    check(n, 100);
    half <= 10'h00A;
    tick(100);
    // Out-of-range edges are ignored as starts but still count as present
    repeat (1200) begin
      @(posedge clk);
      h |= hs[1];
    end
    check(h, 1'b0);
    apb(1'b0, 12'h008, 32'h0, r);
    check({r[12:10], fsoe}, 4'h4);
    ext <= 1'b0;
    period(1, n);
    check(n, 1000);
    tick(4000);
    apb(1'b0, 12'h008, 32'h0, r);
    check(r[12:10], 3'h1);
    period(1, n);
    check(n, 100);
    $display("Test clock modes done");
  endtask : t_sync

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    tick(6);
    rst <= 1'b0;
    t_regs();
    t_start();
    t_switch();
    t_limits();
    t_good();
    t_hiccup();
    t_therm();
    t_sync();
    complete_run();
  end
endmodule : test_buck_protection_sequencer
`default_nettype wire
